// ---- dv/lpw_top_monitor.sv ----
// concurrent checks on the ports of the low power and write protect block
`timescale 1ns/1ps
`include "lpw_consts.svh"

module lpw_chk #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic                    clk,
  input wire logic                    reset,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [11:0]             paddr,
  input wire logic [31:0]             pwdata,
  input wire logic                    pready,
  input wire logic                    wait_exec,
  input wire logic                    wake_any,
  input wire logic                    wake_standby,
  input wire lpw_pkg::lpw_pwr_state_t pwr_state,
  input wire logic                    cpu_clk_stop,
  input wire logic                    periph_clk_stop,
  input wire logic                    osc_stop,
  input wire logic [31:0]             mstop_a,
  input wire logic [31:0]             mstop_b,
  input wire logic [31:0]             mstop_c,
  input wire logic                    mid_speed_mode,
  input wire logic                    sw_reset_pulse
);
  import lpw_pkg::*;

  localparam logic [31:0] CMASK = LARGE_VARIANT ? `LPW_MSTOP_C_MASK : 32'h8000_0000;
  logic       wr;
  logic [2:0] prot_r;
  logic [2:0] prot_nxt;
  logic       sb_sel_r;
  logic       sb_sel_nxt;

  // ****************************************
  // shadow state
  // ****************************************
  // protect and standby select live inside the block, so rebuild them from bus writes
  assign wr = psel && penable && pready && pwrite;
  always_comb begin
    prot_nxt = prot_r;
    sb_sel_nxt = sb_sel_r;
    if (wr && paddr == `LPW_OFS_PROTECT) prot_nxt = pwdata[2:0];
    if (wr && paddr == `LPW_OFS_STANDBY && prot_r[1]) sb_sel_nxt = pwdata[15];
  end
  always_ff @(posedge clk) begin
    prot_r <= reset ? 3'h0 : prot_nxt;
    sb_sel_r <= reset ? 1'b0 : sb_sel_nxt;
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_apb; (psel && !penable) |=> pready ##1 !pready; endproperty
  a_apb: assert property (p_apb) else $error("access phase not answered in one cycle");
  property p_sleep; (pwr_state == PWR_RUN && wait_exec && !sb_sel_r && !mstop_c[31])
    |=> (pwr_state == PWR_SLEEP && !periph_clk_stop); endproperty
  a_sleep: assert property (p_sleep) else $error("wait did not enter sleep");
  property p_deep; (pwr_state == PWR_RUN && wait_exec && !sb_sel_r && mstop_c[31])
    |=> (pwr_state == PWR_DEEP_SLEEP && periph_clk_stop); endproperty
  a_deep: assert property (p_deep) else $error("wait did not enter deep sleep");
  property p_stby; (pwr_state == PWR_RUN && wait_exec && sb_sel_r)
    |=> (pwr_state == PWR_SW_STANDBY && osc_stop); endproperty
  a_stby: assert property (p_stby) else $error("wait did not enter standby");
  property p_stay; (pwr_state == PWR_SW_STANDBY && !wake_standby)
    |=> pwr_state == PWR_SW_STANDBY; endproperty
  a_stay: assert property (p_stay) else $error("standby left without its wake source");
  property p_wake; (pwr_state inside {PWR_SLEEP, PWR_DEEP_SLEEP} && wake_any)
    |=> (pwr_state == PWR_RUN && !cpu_clk_stop); endproperty
  a_wake: assert property (p_wake) else $error("sleep not left on wake");
  property p_stops; cpu_clk_stop == (pwr_state != PWR_RUN)
    && osc_stop == (pwr_state == PWR_SW_STANDBY); endproperty
  a_stops: assert property (p_stops) else $error("stop outputs disagree with state");
  property p_mst_a; (wr && paddr == `LPW_OFS_MSTOP_A) |=> mstop_a ==
    ($past(prot_r[1]) ? ($past(pwdata) & `LPW_MSTOP_A_MASK) : $past(mstop_a)); endproperty
  a_mst_a: assert property (p_mst_a) else $error("stop register a write wrong");
  property p_mst_b; (wr && paddr == `LPW_OFS_MSTOP_B) |=> mstop_b ==
    ($past(prot_r[1]) ? ($past(pwdata) & `LPW_MSTOP_B_MASK) : $past(mstop_b)); endproperty
  a_mst_b: assert property (p_mst_b) else $error("stop register b write wrong");
  property p_mst_c; (wr && paddr == `LPW_OFS_MSTOP_C) |=> mstop_c ==
    ($past(prot_r[1]) ? ($past(pwdata) & CMASK) : $past(mstop_c)); endproperty
  a_mst_c: assert property (p_mst_c) else $error("stop register c write wrong");
  property p_mid; (wr && paddr == `LPW_OFS_OPPWR) |=> mid_speed_mode ==
    ($past(prot_r[1]) ? $past(pwdata[0]) : $past(mid_speed_mode)); endproperty
  a_mid: assert property (p_mid) else $error("power mode write wrong");
  property p_swrst; (wr && paddr == `LPW_OFS_SW_RESET && pwdata == `LPW_SWRST_KEY)
    |=> (sw_reset_pulse == $past(prot_r[1])) ##1 !sw_reset_pulse; endproperty
  a_swrst: assert property (p_swrst) else $error("software reset pulse wrong");
endmodule // lpw_chk

// ---- dv/test_lpw_top.sv ----
// self-checking bench of the low power and write protect block
`timescale 1ns/1ps
`include "lpw_consts.svh"

module test_lpw_top;
  import lpw_pkg::*;

  logic           clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic           wait_exec = 0, wake_any = 0, wake_standby = 0, err;
  logic [11:0]    paddr = 0;
  logic [31:0]    pwdata = 0, prdata, mstop_a, mstop_b, mstop_c, rd, sck, small_mstop_c;
  logic           pready, pslverr, cpu_clk_stop, periph_clk_stop, osc_stop;
  logic           mid_speed_mode, sw_reset_pulse;
  logic [4:0]     clk_div_tick;
  logic [2:0]     f [5];
  lpw_pwr_state_t pwr_state, es;
  int             error_cnt = 0, cmp_count = 0, pulse_cnt = 0, cnt [5];

  lpw_top #(.LARGE_VARIANT(1'b1)) lpw_top_inst (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .wait_exec(wait_exec), .wake_any(wake_any),
    .wake_standby(wake_standby), .pwr_state(pwr_state), .cpu_clk_stop(cpu_clk_stop),
    .periph_clk_stop(periph_clk_stop), .osc_stop(osc_stop), .clk_div_tick(clk_div_tick),
    .mstop_a(mstop_a), .mstop_b(mstop_b), .mstop_c(mstop_c),
    .mid_speed_mode(mid_speed_mode), .sw_reset_pulse(sw_reset_pulse));

  // same bus, smaller variant: its serial unit 11 stop bit is reserved
  lpw_top #(.LARGE_VARIANT(1'b0)) small_lpw_top_inst (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(), .prdata(),
    .pslverr(), .wait_exec(wait_exec), .wake_any(wake_any), .wake_standby(wake_standby),
    .pwr_state(), .cpu_clk_stop(), .periph_clk_stop(), .osc_stop(), .clk_div_tick(),
    .mstop_a(), .mstop_b(), .mstop_c(small_mstop_c), .mid_speed_mode(), .sw_reset_pulse());

  always #50 clk = ~clk;
  always @(posedge clk) if (sw_reset_pulse === 1'b1) pulse_cnt <= pulse_cnt + 1;

  // ****************************************
  // tasks
  // ****************************************
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one idle cycle after each transfer keeps strobes from being driven twice in a step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // a hung slave is left to the watchdog
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(rd, e);
  endtask

  // unlock with the right protect bit, then retry with a wrong one
  task reg_chk(input logic [11:0] a, input int pb, input logic [31:0] m, input logic [31:0] v);
    apb(1'b1, `LPW_OFS_PROTECT, 32'h1 << pb);
    apb(1'b1, a, v);
    rd_chk(a, v & m);
    apb(1'b1, `LPW_OFS_PROTECT, (pb == 0) ? 32'h2 : 32'h1);
    apb(1'b1, a, ~v);
    rd_chk(a, v & m);
  endtask

  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(1));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd_chk(`LPW_OFS_MSTOP_A, `LPW_RST_MSTOP_A);
    rd_chk(`LPW_OFS_MSTOP_B, `LPW_RST_MSTOP_B);
    rd_chk(`LPW_OFS_MSTOP_C, `LPW_RST_MSTOP_C);
    cmp(small_mstop_c, 32'h0000_0000);
    rd_chk(`LPW_OFS_SCK_ONE, `LPW_RST_SCK_ONE);
    $display("reset value test done");
    reg_chk(`LPW_OFS_STANDBY, 1, 32'h0000_8000, $urandom);
    reg_chk(`LPW_OFS_MSTOP_A, 1, `LPW_MSTOP_A_MASK, 32'hFFFF_FFFF);
    reg_chk(`LPW_OFS_MSTOP_A, 1, `LPW_MSTOP_A_MASK, $urandom);
    reg_chk(`LPW_OFS_MSTOP_B, 1, `LPW_MSTOP_B_MASK, $urandom);
    reg_chk(`LPW_OFS_MSTOP_C, 1, `LPW_MSTOP_C_MASK, $urandom);
    apb(1'b1, `LPW_OFS_PROTECT, 32'h2);
    apb(1'b1, `LPW_OFS_MSTOP_C, 32'hFFFF_FFFF);
    cmp(small_mstop_c, `LPW_MSTOP_C_MASK & ~(32'h1 << `LPW_MSTC_SCI11_BIT));
    rd_chk(`LPW_OFS_MSTOP_C, `LPW_MSTOP_C_MASK);
    reg_chk(`LPW_OFS_OPPWR, 1, 32'h1, $urandom);
    reg_chk(`LPW_OFS_SCK_ONE, 0, 32'h0007_7777, $urandom & 32'h0006_6666);
    reg_chk(`LPW_OFS_SYSCTL_ONE, 1, 32'hFF, $urandom);
    reg_chk(`LPW_OFS_FOSC_WAIT, 1, 32'hFF, $urandom);
    reg_chk(`LPW_OFS_FOSC_WAIT, 2, 32'hFF, $urandom);
    for (int i = 0; i < `LPW_CLKGEN_NUM; i++) begin
      reg_chk(`LPW_OFS_CLKGEN_BASE + 12'(4 * i), 0, 32'hFF, $urandom);
    end
    apb(1'b0, 12'h0FC, 32'h0);
    cmp({31'h0, err}, 32'h1);
    cmp(rd, 32'h0000_0000);
    $display("protection test done");
    apb(1'b1, `LPW_OFS_PROTECT, 32'h2);
    apb(1'b1, `LPW_OFS_SW_RESET, `LPW_SWRST_KEY);
    apb(1'b1, `LPW_OFS_PROTECT, 32'h1);
    apb(1'b1, `LPW_OFS_SW_RESET, `LPW_SWRST_KEY);
    cmp(pulse_cnt, 32'h1);
    rd_chk(`LPW_OFS_SW_RESET, 32'h0);
    $display("software reset test done");
    sck = 32'h0;
    for (int j = 0; j < 5; j++) f[j] = 3'($urandom_range(6, 1));
    f[4] = 3'h7;
    for (int j = 0; j < 5; j++) sck = sck | (32'(f[j]) << (4 * j));
    apb(1'b1, `LPW_OFS_PROTECT, 32'h1);
    apb(1'b1, `LPW_OFS_SCK_ONE, sck);
    repeat (70) @(posedge clk);
    for (int j = 0; j < 5; j++) cnt[j] = 0;
    repeat (128) begin
      @(posedge clk);
      for (int j = 0; j < 5; j++) cnt[j] += int'(clk_div_tick[j] === 1'b1);
    end
    for (int j = 0; j < 5; j++) cmp(cnt[j], 128 >> ((f[j] > 3'h6) ? 6 : f[j]));
    $display("divider test done");
    for (int m = 0; m < 3; m++) begin
      es = (m == 0) ? PWR_SLEEP : ((m == 1) ? PWR_DEEP_SLEEP : PWR_SW_STANDBY);
      apb(1'b1, `LPW_OFS_PROTECT, 32'h2);
      apb(1'b1, `LPW_OFS_STANDBY, (m == 2) ? 32'h0000_8000 : 32'h0);
      apb(1'b1, `LPW_OFS_MSTOP_C, (m == 1) ? 32'h8000_0000 : 32'h0);
      wait_exec <= 1'b1;
      @(posedge clk);
      wait_exec <= 1'b0;
      @(posedge clk);
      cmp({30'h0, pwr_state}, {30'h0, es});
      cmp({cpu_clk_stop, periph_clk_stop, osc_stop}, {1'b1, m != 0, m == 2});
      wait_exec <= 1'b1;
      wake_any <= (m == 2);
      @(posedge clk);
      wait_exec <= 1'b0;
      repeat (3) @(posedge clk);
      cmp({30'h0, pwr_state}, {30'h0, es});
      wake_any <= (m != 2);
      wake_standby <= (m == 2);
      repeat (2) @(posedge clk);
      wake_any <= 1'b0;
      wake_standby <= 1'b0;
      @(posedge clk);
      cmp({27'h0, pwr_state, cpu_clk_stop, periph_clk_stop, osc_stop}, 32'h0);
    end
    $display("low power mode test done");
    give_verdict;
  end
endmodule // test_lpw_top

bind lpw_top lpw_chk #(.LARGE_VARIANT(LARGE_VARIANT)) lpw_chk_inst (.clk(clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .wait_exec(wait_exec), .wake_any(wake_any), .wake_standby(wake_standby),
  .pwr_state(pwr_state), .cpu_clk_stop(cpu_clk_stop), .periph_clk_stop(periph_clk_stop),
  .osc_stop(osc_stop), .mstop_a(mstop_a), .mstop_b(mstop_b), .mstop_c(mstop_c),
  .mid_speed_mode(mid_speed_mode), .sw_reset_pulse(sw_reset_pulse));

// ---- logic/lpw_clk_div.sv ----
// one independently programmable clock enable divider
`timescale 1ns/1ps
`include "lpw_consts.svh"

module lpw_clk_div (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire lpw_pkg::lpw_div_sel_t div_sel,
  output logic                       tick
);
  import lpw_pkg::*;

  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic       tick_nxt;

  // ratio is 2**sel; codes above the largest ratio are clamped to it
  function automatic logic [6:0] div_limit(input lpw_div_sel_t sel);
    lpw_div_sel_t s;
    s = (sel > `LPW_DIV_MAX_SEL) ? `LPW_DIV_MAX_SEL : sel;
    return 7'((8'h01 << s) - 8'h01);
  endfunction

  always_comb begin
    tick_nxt = (cnt_r >= div_limit(div_sel));
    cnt_nxt  = tick_nxt ? 7'h00 : 7'(cnt_r + 7'h01);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= 7'h00;
      tick  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end

endmodule // lpw_clk_div

// ---- logic/lpw_consts.svh ----
// register offsets, field positions and reset values of the low power and protect block
`ifndef LPW_CONSTS_SVH
`define LPW_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define LPW_OFS_PROTECT     12'h000
`define LPW_OFS_STANDBY     12'h004
`define LPW_OFS_MSTOP_A     12'h008
`define LPW_OFS_MSTOP_B     12'h00C
`define LPW_OFS_MSTOP_C     12'h010
`define LPW_OFS_OPPWR       12'h014
`define LPW_OFS_SCK_ONE     12'h018
`define LPW_OFS_SYSCTL_ONE  12'h01C
`define LPW_OFS_FOSC_WAIT   12'h020
`define LPW_OFS_SW_RESET    12'h024
`define LPW_OFS_PWR_STATUS  12'h028
`define LPW_OFS_CLKGEN_BASE 12'h040
`define LPW_CLKGEN_NUM      11

// ****************************************
// field positions and masks
// ****************************************
`define LPW_PROTECT_BIT_ZERO_BIT        0
`define LPW_PROTECT_BIT_ONE_BIT        1
`define LPW_PROTECT_BIT_TWO_BIT        2
`define LPW_STANDBY_SELECT_BIT_BIT        15
`define LPW_DEEP_SLEEP_ENABLE_BIT_BIT       31
`define LPW_MSTC_SCI11_BIT  24
`define LPW_OPPWR_MID_BIT   0
`define LPW_MSTOP_A_MASK    32'h008B_00BC
`define LPW_MSTOP_B_MASK    32'h0620_0441
`define LPW_MSTOP_C_MASK    32'h8100_0000
`define LPW_DIV_NUM         5
`define LPW_DIV_STRIDE      4
`define LPW_DIV_MAX_SEL     3'h6
`define LPW_SWRST_KEY       32'h0000_5A5A

// ****************************************
// reset values
// ****************************************
`define LPW_RST_MSTOP_A     32'h008B_00BC
`define LPW_RST_MSTOP_B     32'h0620_0441
`define LPW_RST_MSTOP_C     32'h0100_0000
`define LPW_RST_SCK_ONE     32'h0002_2222

`endif

// ---- logic/lpw_pkg.sv ----
// types shared by the low power and protect block
package lpw_pkg;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_SLEEP,
    PWR_DEEP_SLEEP,
    PWR_SW_STANDBY
  } lpw_pwr_state_t;

  typedef logic [2:0] lpw_div_sel_t;

endpackage

// ---- logic/lpw_top.sv ----
// low power control, module stop, clock divide and write protect block with apb slave
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "lpw_consts.svh"

module lpw_top #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  input  wire logic                    wait_exec,
  input  wire logic                    wake_any,
  input  wire logic                    wake_standby,
  output lpw_pkg::lpw_pwr_state_t      pwr_state,
  output logic                         cpu_clk_stop,
  output logic                         periph_clk_stop,
  output logic                         osc_stop,
  output logic [4:0]                   clk_div_tick,
  output logic [31:0]                  mstop_a,
  output logic [31:0]                  mstop_b,
  output logic [31:0]                  mstop_c,
  output logic                         mid_speed_mode,
  output logic                         sw_reset_pulse
);
  import lpw_pkg::*;

  // ****************************************
  // register state
  // ****************************************
  logic [2:0]  protect_r;
  logic [2:0]  protect_nxt;
  logic [31:0] standby_r;
  logic [31:0] standby_nxt;
  logic [31:0] mstop_a_r;
  logic [31:0] mstop_a_nxt;
  logic [31:0] mstop_b_r;
  logic [31:0] mstop_b_nxt;
  logic [31:0] mstop_c_r;
  logic [31:0] mstop_c_nxt;
  logic        oppwr_r;
  logic        oppwr_nxt;
  logic [31:0] sck_one_r;
  logic [31:0] sck_one_nxt;
  logic [7:0]  sysctl_one_r;
  logic [7:0]  sysctl_one_nxt;
  logic [7:0]  fosc_wait_r;
  logic [7:0]  fosc_wait_nxt;
  logic [7:0]  clkgen_r   [`LPW_CLKGEN_NUM];
  logic [7:0]  clkgen_nxt [`LPW_CLKGEN_NUM];
  logic        swrst_nxt;

  // ****************************************
  // apb handshake state
  // ****************************************
  logic        pready_nxt;
  logic [31:0] prdata_nxt;
  logic        pslverr_nxt;
  logic        wr_take;
  logic        setup;
  logic        hit;
  logic [31:0] rd_val;
  logic [4:0]  cg_slot;
  logic [3:0]  cg_idx;
  logic        cg_hit;
  logic [31:0] mstop_c_mask;

  // smaller part has no serial unit 11, its stop bit stays reserved
  // variant dependent bit
  assign mstop_c_mask = LARGE_VARIANT ? `LPW_MSTOP_C_MASK
                                      : (`LPW_MSTOP_C_MASK & ~(32'h1 << `LPW_MSTC_SCI11_BIT));

  // clock generation registers sit in one indexed bank of byte wide words
  function automatic logic [4:0] clkgen_slot(input logic [11:0] addr);
    logic [11:0] rel;
    rel = 12'(addr - `LPW_OFS_CLKGEN_BASE);
    if (addr >= `LPW_OFS_CLKGEN_BASE && rel[11:2] < 10'(`LPW_CLKGEN_NUM)) begin
      return {1'b1, rel[5:2]};
    end
    return 5'h00;
  endfunction

  // protect bit covering each writable address other than the protect register itself, which is always writable
  function automatic logic write_allowed(input logic [11:0] addr, input logic [2:0] prc);
    logic       ok;
    logic [4:0] slot;
    ok   = 1'b1;
    slot = clkgen_slot(addr);
    case (addr)
      `LPW_OFS_STANDBY, `LPW_OFS_MSTOP_A, `LPW_OFS_MSTOP_B, `LPW_OFS_MSTOP_C,
      `LPW_OFS_OPPWR, `LPW_OFS_SYSCTL_ONE, `LPW_OFS_SW_RESET: begin
        ok = prc[`LPW_PROTECT_BIT_ONE_BIT];
      end
      `LPW_OFS_FOSC_WAIT: begin
        ok = prc[`LPW_PROTECT_BIT_ONE_BIT] | prc[`LPW_PROTECT_BIT_TWO_BIT];
      end
      `LPW_OFS_SCK_ONE: begin
        ok = prc[`LPW_PROTECT_BIT_ZERO_BIT];
      end
      default: begin
        ok = slot[4] ? prc[`LPW_PROTECT_BIT_ZERO_BIT] : 1'b1;
      end
    endcase
    return ok;
  endfunction

  assign setup   = psel & ~penable;
  assign wr_take = psel & penable & pready & pwrite & ~pslverr;
  assign cg_slot = clkgen_slot(paddr);
  assign cg_idx  = cg_slot[3:0];
  assign cg_hit  = cg_slot[4];

  // ****************************************
  // read decode
  // ****************************************
  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      `LPW_OFS_PROTECT:    rd_val = {29'h0, protect_r};
      `LPW_OFS_STANDBY:    rd_val = standby_r;
      `LPW_OFS_MSTOP_A:    rd_val = mstop_a_r;
      `LPW_OFS_MSTOP_B:    rd_val = mstop_b_r;
      `LPW_OFS_MSTOP_C:    rd_val = mstop_c_r;
      `LPW_OFS_OPPWR:      rd_val = {31'h0, oppwr_r};
      `LPW_OFS_SCK_ONE:    rd_val = sck_one_r;
      `LPW_OFS_SYSCTL_ONE: rd_val = {24'h0, sysctl_one_r};
      `LPW_OFS_FOSC_WAIT:  rd_val = {24'h0, fosc_wait_r};
      // write only trigger, reads back zero
      `LPW_OFS_SW_RESET:   rd_val = 32'h0000_0000;
      `LPW_OFS_PWR_STATUS: rd_val = {30'h0, pwr_state};
      default: begin
        if (cg_hit) begin
          rd_val = {24'h0, clkgen_r[cg_idx]};
        end else begin
          hit = 1'b0;
        end
      end
    endcase
  end

  // ****************************************
  // apb slave, one wait free access phase
  // ****************************************
  always_comb begin
    pready_nxt  = setup;
    pslverr_nxt = setup & ~hit;
    prdata_nxt  = prdata;
    if (setup) begin
      prdata_nxt = (hit && !pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= pready_nxt;
      pslverr <= pslverr_nxt;
      prdata  <= prdata_nxt;
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  always_comb begin
    protect_nxt    = protect_r;
    standby_nxt    = standby_r;
    mstop_a_nxt    = mstop_a_r;
    mstop_b_nxt    = mstop_b_r;
    mstop_c_nxt    = mstop_c_r;
    oppwr_nxt      = oppwr_r;
    sck_one_nxt    = sck_one_r;
    sysctl_one_nxt = sysctl_one_r;
    fosc_wait_nxt  = fosc_wait_r;
    clkgen_nxt     = clkgen_r;
    swrst_nxt      = 1'b0;
    if (wr_take && write_allowed(paddr, protect_r)) begin
      case (paddr)
        `LPW_OFS_PROTECT:    protect_nxt = pwdata[2:0];
        `LPW_OFS_STANDBY:    standby_nxt = pwdata & (32'h1 << `LPW_STANDBY_SELECT_BIT_BIT);
        `LPW_OFS_MSTOP_A:    mstop_a_nxt = pwdata & `LPW_MSTOP_A_MASK;
        `LPW_OFS_MSTOP_B:    mstop_b_nxt = pwdata & `LPW_MSTOP_B_MASK;
        `LPW_OFS_MSTOP_C:    mstop_c_nxt = pwdata & mstop_c_mask;
        `LPW_OFS_OPPWR:      oppwr_nxt = pwdata[`LPW_OPPWR_MID_BIT];
        `LPW_OFS_SCK_ONE:    sck_one_nxt = pwdata;
        `LPW_OFS_SYSCTL_ONE: sysctl_one_nxt = pwdata[7:0];
        `LPW_OFS_FOSC_WAIT:  fosc_wait_nxt = pwdata[7:0];
        `LPW_OFS_SW_RESET:   swrst_nxt = (pwdata == `LPW_SWRST_KEY);
        default: begin
          if (cg_hit) begin
            clkgen_nxt[cg_idx] = pwdata[7:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      protect_r      <= 3'h0;
      standby_r      <= 32'h0000_0000;
      mstop_a_r      <= `LPW_RST_MSTOP_A;
      mstop_b_r      <= `LPW_RST_MSTOP_B;
      // reserved bit of the smaller part must not come out of reset set
      mstop_c_r      <= `LPW_RST_MSTOP_C & mstop_c_mask;
      oppwr_r        <= 1'b0;
      sck_one_r      <= `LPW_RST_SCK_ONE;
      sysctl_one_r   <= 8'h00;
      fosc_wait_r    <= 8'h00;
      sw_reset_pulse <= 1'b0;
      for (int i = 0; i < `LPW_CLKGEN_NUM; i++) begin
        clkgen_r[i] <= 8'h00;
      end
    end else begin
      protect_r      <= protect_nxt;
      standby_r      <= standby_nxt;
      mstop_a_r      <= mstop_a_nxt;
      mstop_b_r      <= mstop_b_nxt;
      mstop_c_r      <= mstop_c_nxt;
      oppwr_r        <= oppwr_nxt;
      sck_one_r      <= sck_one_nxt;
      sysctl_one_r   <= sysctl_one_nxt;
      fosc_wait_r    <= fosc_wait_nxt;
      sw_reset_pulse <= swrst_nxt;
      clkgen_r       <= clkgen_nxt;
    end
  end

  // stop vectors mirror their registers; the deep sleep bit leaves as bit 31 of mstop_c
  assign mstop_a        = mstop_a_r;
  assign mstop_b        = mstop_b_r;
  assign mstop_c        = mstop_c_r;
  assign mid_speed_mode = oppwr_r;

  // ****************************************
  // independent clock dividers
  // ****************************************
  // one divider per clock
  for (genvar g = 0; g < `LPW_DIV_NUM; g++) begin : g_div
    lpw_clk_div u_div (
      .clk     (clk),
      .reset   (reset),
      .div_sel (lpw_div_sel_t'(sck_one_r[g*`LPW_DIV_STRIDE +: 3])),
      .tick    (clk_div_tick[g])
    );
  end

  // ****************************************
  // low power mode sequencer
  // ****************************************
  lpw_wait_ctrl u_wait (
    .clk             (clk),
    .reset           (reset),
    .wait_exec       (wait_exec),
    .standby_sel     (standby_r[`LPW_STANDBY_SELECT_BIT_BIT]),
    .deep_sleep_en   (mstop_c_r[`LPW_DEEP_SLEEP_ENABLE_BIT_BIT]),
    .wake_any        (wake_any),
    .wake_standby    (wake_standby),
    .state           (pwr_state),
    .cpu_clk_stop    (cpu_clk_stop),
    .periph_clk_stop (periph_clk_stop),
    .osc_stop        (osc_stop)
  );

endmodule // lpw_top

// ---- logic/lpw_wait_ctrl.sv ----
// wait instruction entry and wake-up sequencing of the low power modes
`timescale 1ns/1ps
`include "lpw_consts.svh"

module lpw_wait_ctrl (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    wait_exec,
  input  wire logic                    standby_sel,
  input  wire logic                    deep_sleep_en,
  input  wire logic                    wake_any,
  input  wire logic                    wake_standby,
  output lpw_pkg::lpw_pwr_state_t      state,
  output logic                         cpu_clk_stop,
  output logic                         periph_clk_stop,
  output logic                         osc_stop
);
  import lpw_pkg::*;

  lpw_pwr_state_t state_nxt;
  logic           cpu_stop_nxt;
  logic           periph_stop_nxt;
  logic           osc_stop_nxt;

  always_comb begin
    state_nxt = state;
    case (state)
      PWR_RUN: begin
        if (wait_exec) begin
          if (standby_sel) begin
            state_nxt = PWR_SW_STANDBY;
          end else if (deep_sleep_en) begin
            state_nxt = PWR_DEEP_SLEEP;
          end else begin
            state_nxt = PWR_SLEEP;
          end
        end
      end
      // sleep and deep sleep return on any interrupt
      PWR_SLEEP, PWR_DEEP_SLEEP: begin
        if (wake_any) begin
          state_nxt = PWR_RUN;
        end
      end
      // only nmi and external pin interrupts reach a stopped oscillator
      PWR_SW_STANDBY: begin
        if (wake_standby) begin
          state_nxt = PWR_RUN;
        end
      end
      default: begin
        state_nxt = PWR_RUN;
      end
    endcase
    cpu_stop_nxt    = (state_nxt != PWR_RUN);
    periph_stop_nxt = (state_nxt == PWR_DEEP_SLEEP) || (state_nxt == PWR_SW_STANDBY);
    osc_stop_nxt    = (state_nxt == PWR_SW_STANDBY);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state           <= PWR_RUN;
      cpu_clk_stop    <= 1'b0;
      periph_clk_stop <= 1'b0;
      osc_stop        <= 1'b0;
    end else begin
      state           <= state_nxt;
      cpu_clk_stop    <= cpu_stop_nxt;
      periph_clk_stop <= periph_stop_nxt;
      osc_stop        <= osc_stop_nxt;
    end
  end

endmodule // lpw_wait_ctrl
